// [core/gpio_pkg.sv]
// Constants, register map and types for the pin port block
package gpio_pkg;
    localparam int port_width = 32;
    localparam int num_ports = 2;
    localparam int total_pins = 50;
    localparam int addr_width = 8;
    // Word offsets, byte address = 4 x index
    localparam logic [5:0] reg_out = 6'h00;
    localparam logic [5:0] reg_in = 6'h01;
    localparam logic [5:0] reg_dir = 6'h02;
    localparam logic [5:0] reg_oe_ctl = 6'h03;
    localparam logic [5:0] reg_alt_sel = 6'h04;
    localparam logic [5:0] reg_pull_en = 6'h05;
    localparam logic [5:0] reg_pull_up = 6'h06;
    localparam logic [5:0] reg_drive = 6'h07;
    localparam logic [5:0] reg_int_en = 6'h08;
    localparam logic [5:0] reg_int_edge = 6'h09;
    localparam logic [5:0] reg_int_pol = 6'h0a;
    localparam logic [5:0] reg_int_flag = 6'h0b;
    localparam logic [5:0] reg_wake_en = 6'h0c;
    localparam logic [5:0] reg_wake_rise = 6'h0d;
    localparam logic [5:0] reg_wake_flag = 6'h0e;
    localparam int regs_per_port = 16;
    localparam logic [31:0] reset_zero = 32'h0000_0000;
    localparam logic [31:0] unmapped_value = 32'h0000_0000;
    localparam logic [31:0] port0_mask = 32'hffff_ffff;
    localparam logic [31:0] port1_mask = 32'h0003_ffff;

    typedef struct packed {
        logic [31:0] out;
        logic [31:0] dir;
        logic [31:0] oe_ctl;
        logic [31:0] alt_sel;
        logic [31:0] pull_en;
        logic [31:0] pull_up;
        logic [31:0] drive;
        logic [31:0] int_en;
        logic [31:0] int_edge;
        logic [31:0] int_pol;
        logic [31:0] wake_en;
        logic [31:0] wake_rise;
    } port_cfg_t;
endpackage

// [core/port_cfg_if.sv]
// Bundle between the bus slave and one port's pin logic
`timescale 1ns/1ps
interface port_cfg_if;
    import gpio_pkg::*;
    port_cfg_t cfg;
    logic [31:0] clr_flag;
    logic [31:0] clr_wake;
    logic [31:0] pin_level;
    logic [31:0] int_flag;
    logic [31:0] wake_flag;
    modport ctrl (output cfg, output clr_flag, output clr_wake,
                  input pin_level, input int_flag, input wake_flag);
    modport port (input cfg, input clr_flag, input clr_wake,
                  output pin_level, output int_flag, output wake_flag);
endinterface

// [core/gpio_port_slice.sv]
// One port of up to 32 pins, set by pin_mask: pads, synchronisers, interrupt and wake detection
`timescale 1ns/1ps
module gpio_port_slice #(
    parameter logic [31:0] pin_mask = 32'hffff_ffff
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic hold_in,
    port_cfg_if.port bus,
    input wire logic [31:0] pad_in,
    input wire logic [31:0] alt_out_in,
    input wire logic [31:0] alt_oe_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe_out,
    output logic [31:0] pull_up_out,
    output logic [31:0] pull_down_out,
    output logic [31:0] high_drive_out,
    output logic [31:0] alt_in_out
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] prev;
        logic [31:0] flag;
        logic [31:0] wake;
        logic [31:0] pad_o;
        logic [31:0] pad_e;
        logic [31:0] pu;
        logic [31:0] pd;
        logic [31:0] hd;
    } slice_t;

    slice_t s;
    slice_t next_s;

    always_comb begin
        logic [31:0] lvl;
        logic [31:0] rise;
        logic [31:0] fall;
        logic [31:0] hit;
        lvl = s.sync2;
        rise = lvl & ~s.prev;
        fall = ~lvl & s.prev;
        hit = reset_zero;
        next_s = s;
        next_s.sync1 = pad_in & pin_mask;
        next_s.sync2 = s.sync1;
        next_s.prev = lvl;
        // Edge by polarity, else active level; per-pin choice
        hit = (bus.cfg.int_edge & ((bus.cfg.int_pol & rise) | (~bus.cfg.int_pol & fall))) |
              (~bus.cfg.int_edge & ~(lvl ^ bus.cfg.int_pol));
        // Set wins over a simultaneous clear
        next_s.flag = ((s.flag & ~bus.clr_flag) | hit) & pin_mask;
        next_s.wake = ((s.wake & ~bus.clr_wake) |
                       (bus.cfg.wake_en & ((bus.cfg.wake_rise & rise) | (~bus.cfg.wake_rise & fall))))
                      & pin_mask;
        // Pads frozen while asleep so loads see no glitch
        if (!hold_in) begin
            // Alternate function owns output path, re-evaluated every cycle
            next_s.pad_o = (bus.cfg.alt_sel & alt_out_in) | (~bus.cfg.alt_sel & bus.cfg.out);
            // dir=1 output, oe_ctl adds bidir drive; both clear is hi-z input
            next_s.pad_e = ((bus.cfg.alt_sel & alt_oe_in) |
                            (~bus.cfg.alt_sel & (bus.cfg.dir | bus.cfg.oe_ctl))) & pin_mask;
            next_s.pu = bus.cfg.pull_en & bus.cfg.pull_up & ~next_s.pad_e & pin_mask;
            next_s.pd = bus.cfg.pull_en & ~bus.cfg.pull_up & ~next_s.pad_e & pin_mask;
            next_s.hd = bus.cfg.drive & pin_mask;
        end
        if (!rstn_in) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        s <= next_s;
    end

    assign bus.pin_level = s.sync2;
    assign bus.int_flag = s.flag;
    assign bus.wake_flag = s.wake;
    assign pad_out = s.pad_o;
    assign pad_oe_out = s.pad_e;
    assign pull_up_out = s.pu;
    assign pull_down_out = s.pd;
    assign high_drive_out = s.hd;
    assign alt_in_out = s.sync2 & bus.cfg.alt_sel;
endmodule

// [core/gpio_regs.sv]
// Avalon-MM register file for one port's configuration
`timescale 1ns/1ps
module gpio_regs #(
    parameter logic [31:0] pin_mask = 32'hffff_ffff
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic sel_in,
    input wire logic [5:0] index_in,
    input wire logic write_in,
    input wire logic [3:0] be_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    port_cfg_if.ctrl bus
);
    import gpio_pkg::*;

    port_cfg_t c;
    port_cfg_t next_c;
    logic [31:0] bmask;
    logic [31:0] wv;

    assign bmask = {{8{be_in[3]}}, {8{be_in[2]}}, {8{be_in[1]}}, {8{be_in[0]}}};
    assign wv = wdata_in & pin_mask;

    always_comb begin
        next_c = c;
        if (sel_in && write_in) begin
            unique case (index_in)
                reg_out: next_c.out = (c.out & ~bmask) | (wv & bmask);
                reg_dir: next_c.dir = (c.dir & ~bmask) | (wv & bmask);
                reg_oe_ctl: next_c.oe_ctl = (c.oe_ctl & ~bmask) | (wv & bmask);
                reg_alt_sel: next_c.alt_sel = (c.alt_sel & ~bmask) | (wv & bmask);
                reg_pull_en: next_c.pull_en = (c.pull_en & ~bmask) | (wv & bmask);
                reg_pull_up: next_c.pull_up = (c.pull_up & ~bmask) | (wv & bmask);
                reg_drive: next_c.drive = (c.drive & ~bmask) | (wv & bmask);
                reg_int_en: next_c.int_en = (c.int_en & ~bmask) | (wv & bmask);
                reg_int_edge: next_c.int_edge = (c.int_edge & ~bmask) | (wv & bmask);
                reg_int_pol: next_c.int_pol = (c.int_pol & ~bmask) | (wv & bmask);
                reg_wake_en: next_c.wake_en = (c.wake_en & ~bmask) | (wv & bmask);
                reg_wake_rise: next_c.wake_rise = (c.wake_rise & ~bmask) | (wv & bmask);
                default: next_c = c;
            endcase
        end
        if (!rstn_in) begin
            next_c = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        c <= next_c;
    end

    assign bus.cfg = c;
    assign bus.clr_flag = (sel_in && write_in && index_in == reg_int_flag) ? (wv & bmask) : reset_zero;
    assign bus.clr_wake = (sel_in && write_in && index_in == reg_wake_flag) ? (wv & bmask) : reset_zero;

    always_comb begin
        unique case (index_in)
            reg_out: rdata_out = c.out;
            reg_in: rdata_out = bus.pin_level;
            reg_dir: rdata_out = c.dir;
            reg_oe_ctl: rdata_out = c.oe_ctl;
            reg_alt_sel: rdata_out = c.alt_sel;
            reg_pull_en: rdata_out = c.pull_en;
            reg_pull_up: rdata_out = c.pull_up;
            reg_drive: rdata_out = c.drive;
            reg_int_en: rdata_out = c.int_en;
            reg_int_edge: rdata_out = c.int_edge;
            reg_int_pol: rdata_out = c.int_pol;
            reg_int_flag: rdata_out = bus.int_flag;
            reg_wake_en: rdata_out = c.wake_en;
            reg_wake_rise: rdata_out = c.wake_rise;
            reg_wake_flag: rdata_out = bus.wake_flag;
            default: rdata_out = unmapped_value;
        endcase
    end
endmodule

// [core/gpio_port_top.sv]
// Top: two pin ports behind one Avalon-MM slave
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module gpio_port_top (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [gpio_pkg::addr_width-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic deep_sleep_in,
    input wire logic [63:0] pad_in,
    input wire logic [63:0] alt_out_in,
    input wire logic [63:0] alt_oe_in,
    output logic [63:0] pad_out,
    output logic [63:0] pad_oe_out,
    output logic [63:0] pull_up_out,
    output logic [63:0] pull_down_out,
    output logic [63:0] high_drive_out,
    output logic [63:0] alt_in_out,
    output logic [1:0] port_irq_out,
    output logic wake_out
);
    import gpio_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic sleep1;
        logic sleep2;
    } top_t;

    top_t t;
    top_t next_t;
    logic req;
    logic [31:0] rd [num_ports];
    logic [num_ports-1:0] wake_any;
    logic [31:0] rd_sel;

    // One wait cycle: request answered at the second edge it is held
    assign req = (avs_read_in || avs_write_in) && !t.ack;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !t.ack;
    assign avs_readdata_out = t.rdata;

    genvar p;
    generate
        for (p = 0; p < num_ports; p++) begin : g_port
            localparam logic [31:0] msk = (p == 0) ? port0_mask : port1_mask;
            port_cfg_if cif();
            logic sel;
            assign sel = req && (avs_address_in[addr_width-1:6] == 2'(p)) && avs_write_in;
            gpio_regs #(.pin_mask(msk)) u_regs (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .sel_in(sel),
                .index_in(avs_address_in[5:0] >> 2),
                .write_in(avs_write_in),
                .be_in(avs_byteenable_in),
                .wdata_in(avs_writedata_in),
                .rdata_out(rd[p]),
                .bus(cif.ctrl)
            );
            gpio_port_slice #(.pin_mask(msk)) u_slice (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .hold_in(t.sleep2),
                .bus(cif.port),
                .pad_in(pad_in[p*32 +: 32]),
                .alt_out_in(alt_out_in[p*32 +: 32]),
                .alt_oe_in(alt_oe_in[p*32 +: 32]),
                .pad_out(pad_out[p*32 +: 32]),
                .pad_oe_out(pad_oe_out[p*32 +: 32]),
                .pull_up_out(pull_up_out[p*32 +: 32]),
                .pull_down_out(pull_down_out[p*32 +: 32]),
                .high_drive_out(high_drive_out[p*32 +: 32]),
                .alt_in_out(alt_in_out[p*32 +: 32])
            );
            assign port_irq_out[p] = |(cif.int_flag & cif.cfg.int_en);
            assign wake_any[p] = |cif.wake_flag;
        end
    endgenerate

    assign wake_out = |wake_any;

    always_comb begin
        rd_sel = unmapped_value;
        if (avs_address_in[addr_width-1:6] == 2'd0) begin
            rd_sel = rd[0];
        end else if (avs_address_in[addr_width-1:6] == 2'd1) begin
            rd_sel = rd[1];
        end
    end

    always_comb begin
        next_t = t;
        next_t.ack = req;
        next_t.sleep1 = deep_sleep_in;
        next_t.sleep2 = t.sleep1;
        if (req && avs_read_in) begin
            next_t.rdata = rd_sel;
        end
        if (!rstn_in) begin
            next_t = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        t <= next_t;
    end
endmodule

// [verification/gpio_port_chk.sv]
// Assertions on the port block's top-level pins
`timescale 1ns/1ps
module gpio_port_chk (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [gpio_pkg::addr_width-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic deep_sleep_in,
    input wire logic [63:0] pad_out,
    input wire logic [63:0] pad_oe_out,
    input wire logic [63:0] pull_up_out,
    input wire logic [63:0] pull_down_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    a_wait_one_cycle: assert property ($rose(avs_read_in | avs_write_in) |->
        avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("waitrequest not exactly one cycle");
    a_idle_no_wait: assert property (!(avs_read_in | avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest while idle");
    a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out &&
        (avs_address_in[7] || avs_address_in[5:2] == 4'hf) |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_port1_top_zero: assert property (avs_read_in && !avs_waitrequest_out &&
        avs_address_in[7:6] == 2'b01 |-> avs_readdata_out[31:18] == 14'h0) else $error("absent pin bits read");
    a_no_absent_drive: assert property (pad_oe_out[63:50] == 14'h0) else $error("absent pin driven");
    a_pull_off_drive: assert property (((pull_up_out | pull_down_out) & pad_oe_out) == 64'h0)
        else $error("pull on a driven pin");
    a_pull_one_way: assert property ((pull_up_out & pull_down_out) == 64'h0) else $error("both pulls on");
    a_sleep_hold: assert property (deep_sleep_in [*4] |=> $stable(pad_out) && $stable(pad_oe_out)
        && $stable(pull_up_out)) else $error("pin moved in deep sleep");
endmodule

// [verification/pin_world.sv]
// External circuitry on the pins: other drivers, pulls, floating lines
`timescale 1ns/1ps
module pin_world (
    input wire logic clk_in,
    input wire logic [63:0] pad_val_in,
    input wire logic [63:0] pad_oe_in,
    input wire logic [63:0] pull_up_in,
    input wire logic [63:0] pull_down_in,
    input wire logic [63:0] ext_val_in,
    input wire logic [63:0] ext_en_in,
    output logic [63:0] level_out
);
    logic [63:0] flt = 64'h0;
    // Undriven line never settles, so a missed pull is seen
    always @(posedge clk_in) begin
        flt <= ~flt;
    end
    assign level_out = (pad_oe_in & pad_val_in) | (~pad_oe_in & ext_en_in & ext_val_in)
        | (~pad_oe_in & ~ext_en_in & (pull_up_in | (~pull_down_in & flt)));
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the two-port pin block
`timescale 1ns/1ps
module tb_top;
    import gpio_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] avs_address_in = 8'h0;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0, deep_sleep_in = 1'b0;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic avs_waitrequest_out, wake_out;
    logic [63:0] pad_in, pad_out, pad_oe_out, pull_up_out, pull_down_out, high_drive_out, alt_in_out;
    logic [63:0] alt_out_in = 64'h0, alt_oe_in = 64'h0, ext_val = 64'h0, ext_en = {64{1'b1}};
    logic [1:0] port_irq_out;
    int bad_count = 0, check_count = 0;
    always #5 clk_in = ~clk_in;
    gpio_port_top u_gpio_port_top (.clk_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .deep_sleep_in,
        .pad_in, .alt_out_in, .alt_oe_in, .pad_out, .pad_oe_out, .pull_up_out, .pull_down_out,
        .high_drive_out, .alt_in_out, .port_irq_out, .wake_out);
    pin_world u_pin_world (.clk_in, .pad_val_in(pad_out), .pad_oe_in(pad_oe_out), .pull_up_in(pull_up_out),
        .pull_down_in(pull_down_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pad_in));
    task final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until waitrequest is seen low, then released
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        // Only the watchdog ends a wait that never finishes
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task w(input logic [1:0] p, input logic [5:0] i, input logic [31:0] d);
        bus(1'b1, {p, i[3:0], 2'b00}, d);
    endtask
    task r(input string what, input logic [1:0] p, input logic [5:0] i, input logic [31:0] exp);
        bus(1'b0, {p, i[3:0], 2'b00}, 32'h0);
        chk(what, {32'h0, exp}, {32'h0, rd});
    endtask
    task t_ports;
        r("dir p0", 0, reg_dir, 32'h0);
        chk("oe reset", 64'h0, pad_oe_out);
        ext_en[0] <= 1'b0;
        w(0, reg_dir, 32'h1);
        w(0, reg_out, 32'h1);
        repeat (4) @(posedge clk_in);
        chk("pad drive", 64'h1, pad_out & pad_oe_out);
        r("in p0", 0, reg_in, 32'h1);
        w(1, reg_dir, 32'hffff_ffff);
        r("dir p1", 1, reg_dir, port1_mask);
        chk("oe p1", 64'h0003_ffff_0000_0001, pad_oe_out);
        w(1, reg_dir, 32'h0);
        w(1, reg_oe_ctl, 32'h1);
        w(2, reg_dir, 32'hffff_ffff);
        r("dir kept", 0, reg_dir, 32'h1);
        chk("oe bidir", 64'h0000_0001_0000_0001, pad_oe_out);
        avs_byteenable_in <= 4'h2;
        w(0, reg_drive, 32'h0000_ff04);
        avs_byteenable_in <= 4'hf;
        r("byte lane", 0, reg_drive, 32'h0000_ff00);
        r("unmapped", 3, reg_out, 32'h0);
        r("index f", 0, 6'h0f, 32'h0);
    endtask
    task t_alt;
        alt_oe_in[0] <= 1'b1;
        w(0, reg_alt_sel, 32'h1);
        repeat (3) @(posedge clk_in);
        chk("alt owns pin", 64'h0, {63'h0, pad_out[0]});
        alt_oe_in[0] <= 1'b0;
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk("alt input", 64'h1, {63'h0, alt_in_out[0]});
        ext_en[0] <= 1'b0;
        ext_val[0] <= 1'b0;
        w(0, reg_alt_sel, 32'h0);
        repeat (3) @(posedge clk_in);
        chk("firmware back", 64'h1, {63'h0, pad_out[0]});
    endtask
    task t_pull;
        ext_en[1] <= 1'b0;
        w(0, reg_pull_en, 32'h2);
        w(0, reg_pull_up, 32'h2);
        w(0, reg_drive, 32'h4);
        repeat (3) @(posedge clk_in);
        chk("pull up", 64'h2, pull_up_out);
        chk("high drive", 64'h4, high_drive_out);
        r("pulled high", 0, reg_in, 32'h3);
        w(0, reg_pull_up, 32'h0);
        repeat (3) @(posedge clk_in);
        chk("pull down", 64'h2, pull_down_out);
        r("pulled low", 0, reg_in, 32'h1);
        ext_en[1] <= 1'b1;
    endtask
    task t_irq;
        w(0, reg_int_en, 32'h18);
        w(0, reg_int_edge, 32'hffff_ffef);
        w(0, reg_int_pol, 32'hffff_ffff);
        w(0, reg_int_flag, 32'hffff_ffff);
        ext_val[5:3] <= 3'b101;
        repeat (6) @(posedge clk_in);
        chk("irq edge", 64'h1, {62'h0, port_irq_out});
        r("flags", 0, reg_int_flag, 32'h28);
        w(0, reg_int_flag, 32'h28);
        repeat (3) @(posedge clk_in);
        chk("irq clear", 64'h0, {62'h0, port_irq_out});
        ext_val[4] <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("irq level", 64'h1, {62'h0, port_irq_out});
        w(0, reg_int_flag, 32'h10);
        r("level again", 0, reg_int_flag, 32'h10);
        w(0, reg_int_en, 32'h8);
        repeat (3) @(posedge clk_in);
        chk("irq masked", 64'h0, {62'h0, port_irq_out});
        w(1, reg_int_en, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("irq port1", 64'h2, {62'h0, port_irq_out});
        w(1, reg_int_en, 32'h0);
    endtask
    task t_wake;
        w(0, reg_wake_en, 32'h40);
        w(0, reg_wake_flag, 32'hffff_ffff);
        ext_val[6] <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("no wake rise", 64'h0, {63'h0, wake_out});
        ext_val[6] <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("wake fall", 64'h1, {63'h0, wake_out});
        w(0, reg_wake_rise, 32'h40);
        w(0, reg_wake_flag, 32'h40);
        repeat (3) @(posedge clk_in);
        chk("wake clear", 64'h0, {63'h0, wake_out});
        ext_val[6] <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("wake rise", 64'h1, {63'h0, wake_out});
    endtask
    task t_sleep;
        deep_sleep_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        w(0, reg_out, 32'h0);
        repeat (4) @(posedge clk_in);
        chk("sleep hold", 64'h1, {63'h0, pad_out[0]});
        deep_sleep_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk("after wake", 64'h0, {63'h0, pad_out[0]});
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_ports;
        t_alt;
        t_pull;
        t_irq;
        t_wake;
        t_sleep;
        final_report;
    end
    // Whole run is a few hundred cycles; this catches a hung handshake
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        final_report;
    end
endmodule
bind gpio_port_top gpio_port_chk u_gpio_port_chk (.clk_in, .rstn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .deep_sleep_in, .pad_out, .pad_oe_out,
    .pull_up_out, .pull_down_out);
